// >>> include/pid_pkg.sv
// constants, types and register map of the process controller.
// assumes a 250 MHz clock; percent values use 16000 counts for 100.0 %.
package pid_pkg;
	localparam int CLK_NS = 4;
	localparam int SAMPLE_NS = 1000000;
	localparam int SLEW_UNIT_NS = 100000000;
	localparam int FS = 16000;
	localparam int GAIN_ONE = 1000;
	localparam int LIM_UNIT = FS / 1000;
	localparam int D_MUL = 1000000000 / SAMPLE_NS;
	localparam int INT_DIV = GAIN_ONE * D_MUL;
	localparam longint SLEW_NUM = longint'(FS) * 65536 * SAMPLE_NS / SLEW_UNIT_NS;
	localparam logic [5:0] DIV_STEPS = 6'h20;
	localparam logic [15:0] UNUSED_CODE = 16'h0000;
	localparam logic [15:0] SLEW_MIN = 16'h0001;
	localparam logic [15:0] SLEW_MAX = 16'h7ff8;
	localparam logic [7:0] REG_MAIN_SEL = 8'h00;
	localparam logic [7:0] REG_REF_SEL = 8'h01;
	localparam logic [7:0] REG_FB_SEL = 8'h02;
	localparam logic [7:0] REG_CTRL = 8'h03;
	localparam logic [7:0] REG_SLEW = 8'h04;
	localparam logic [7:0] REG_EN_SEL = 8'h05;
	localparam logic [7:0] REG_KP = 8'h06;
	localparam logic [7:0] REG_KI = 8'h07;
	localparam logic [7:0] REG_KD = 8'h08;
	localparam logic [7:0] REG_HI = 8'h09;
	localparam logic [7:0] REG_LO = 8'h0a;
	localparam logic [7:0] REG_SCALE = 8'h0b;
	localparam logic [7:0] REG_DEST_SEL = 8'h0c;
	localparam logic [7:0] REG_OUT_MON = 8'h10;
	localparam logic [7:0] REG_REF_MON = 8'h11;
	localparam logic [7:0] REG_FB_MON = 8'h12;
	localparam logic [7:0] REG_ERR_MON = 8'h13;
	localparam logic [7:0] REG_MAIN_MON = 8'h14;
	localparam logic [7:0] REG_SCALED_MON = 8'h15;
	localparam int CTL_REF_INV = 0;
	localparam int CTL_FB_INV = 1;
	localparam int CTL_EN = 2;

	typedef struct packed {
		logic [15:0] main_sel;
		logic [15:0] ref_sel;
		logic [15:0] fb_sel;
		logic [15:0] en_sel;
		logic [15:0] dest_sel;
		logic [15:0] slew;
		logic [15:0] kp;
		logic [15:0] ki;
		logic [15:0] kd;
		logic [15:0] hi;
		logic [15:0] lo;
		logic [15:0] scale;
		logic ref_inv;
		logic fb_inv;
		logic ctrl_en;
	} cfg_t;

	localparam cfg_t CFG_RST = '{main_sel: UNUSED_CODE, ref_sel: UNUSED_CODE,
		fb_sel: UNUSED_CODE, en_sel: UNUSED_CODE, dest_sel: UNUSED_CODE,
		slew: 16'h0001, kp: 16'h03e8, ki: 16'h01f4, kd: 16'h0000, hi: 16'h03e8,
		lo: 16'hfc18, scale: 16'h03e8, ref_inv: 1'b0, fb_inv: 1'b0, ctrl_en: 1'b0};

	typedef struct packed {
		logic valid;
		logic bipolar;
		logic [15:0] value;
		logic [15:0] max;
	} src_t;

	typedef struct packed {
		logic valid;
		logic bit_val;
	} en_src_t;

	typedef struct packed {
		logic valid;
		logic [15:0] max;
	} dest_t;

	typedef enum logic [2:0] {ST_IDLE, ST_MAIN, ST_REF, ST_FB, ST_SLEW, ST_CALC} state_t;
endpackage

// >>> core/pid_divider.sv
// unsigned restoring divider, 32 by 16 bits, one quotient bit per clock.
// assumes start is a single-cycle pulse given only while the divider is idle.
module pid_divider (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic start_i,
	input wire logic [31:0] dividend_i,
	input wire logic [15:0] divisor_i,
	output logic done_o,
	output logic [31:0] quot_o
);
	logic [16:0] rem_r, rem_nxt;
	logic [31:0] quo_r, quo_nxt;
	logic [15:0] den_r, den_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;
	logic done_r, done_nxt;
	logic [16:0] shifted;
	logic [17:0] trial;

	always_comb begin
		rem_nxt = rem_r;
		quo_nxt = quo_r;
		den_nxt = den_r;
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		shifted = {rem_r[15:0], quo_r[31]};
		trial = {1'b0, shifted} - {2'b00, den_r};
		if (start_i) begin
			rem_nxt = '0;
			quo_nxt = dividend_i;
			den_nxt = divisor_i;
			cnt_nxt = pid_pkg::DIV_STEPS;
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			// a borrow means the trial subtraction failed: keep the shifted remainder
			rem_nxt = trial[17] ? shifted : trial[16:0];
			quo_nxt = {quo_r[30:0], ~trial[17]};
			cnt_nxt = cnt_r - 6'h01;
			if (cnt_r == 6'h01) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rem_r <= '0;
			quo_r <= '0;
			den_r <= '0;
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			rem_r <= rem_nxt;
			quo_r <= quo_nxt;
			den_r <= den_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign done_o = done_r;
	assign quot_o = quo_r;
endmodule

// >>> core/pid_process_controller.sv
// process controller: source normalisation, reference ramp, pid, limits, scaling.
// assumes source, enable and destination lookups are done by same-clock logic
// that answers for the selector codes this block drives out.
//
// Summary of operation
// - invalid source selection gives zero input
// - inputs normalised to bipolar or unipolar percent
// - main source at maximum reads full scale
// - reference source at maximum reads full scale
// - feedback source at maximum reads full scale
// - source selectors default unused, acting as zero
// - reference invert bit negates reference
// - feedback invert bit negates feedback
// - reference ramps zero to full in slew time
// - negative to positive full takes twice
// - enable bit zero forces output zero
// - enable source bit ANDed with enable bit
// - invalid or unused enable source means one
// - proportional gain multiplies error, default one
// - integral gain multiplies error, default half
// - derivative gain multiplies error change, default zero
// - output clamped at upper limit
// - output clamped at lower limit
// - limited output plus main reference scaled
// - unity integral gain ramps full scale per second
// - invalid destination receives no write
// - full output drives destination to maximum
//
// The strobed register port and the placing of the registers are this design's own decisions.
module pid_process_controller #(
	parameter int SAMPLE_CYCLES = pid_pkg::SAMPLE_NS / pid_pkg::CLK_NS
) (
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O,
	output logic [15:0] MAIN_SEL_O,
	output logic [15:0] REF_SEL_O,
	output logic [15:0] FB_SEL_O,
	output logic [15:0] EN_SEL_O,
	output logic [15:0] DEST_SEL_O,
	input wire pid_pkg::src_t MAIN_SRC_I,
	input wire pid_pkg::src_t REF_SRC_I,
	input wire pid_pkg::src_t FB_SRC_I,
	input wire pid_pkg::en_src_t EN_SRC_I,
	input wire pid_pkg::dest_t DEST_I,
	output logic DEST_WR_O,
	output logic [15:0] DEST_DATA_O
);
	localparam logic signed [47:0] FS48 = 48'(pid_pkg::FS);

	pid_pkg::cfg_t cfg_r, cfg_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	pid_pkg::state_t state_r, state_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic launched_r, launched_nxt;
	logic neg_r, neg_nxt;
	logic signed [47:0] main_r, main_nxt;
	logic signed [47:0] tgt_r, tgt_nxt;
	logic signed [47:0] fb_r, fb_nxt;
	logic [31:0] step_r, step_nxt;
	logic signed [47:0] ref_acc_r, ref_acc_nxt;
	logic signed [47:0] err_r, err_nxt;
	logic signed [47:0] integ_r, integ_nxt;
	logic signed [47:0] pid_r, pid_nxt;
	logic signed [47:0] scaled_r, scaled_nxt;
	logic dest_wr_r, dest_wr_nxt;
	logic [15:0] dest_data_r, dest_data_nxt;

	logic enabled;
	logic div_start;
	logic div_done;
	logic [31:0] div_quot;
	logic [31:0] dividend;
	logic [15:0] divisor;
	logic src_neg;
	logic signed [47:0] norm;
	logic signed [47:0] ref_now, err_raw, p_term, i_term, d_term, sum, hi_q, lo_q;
	logic signed [47:0] tgt_fix, step_fix, integ_add, out_sum;

	function automatic logic signed [47:0] clamp(input logic signed [47:0] x,
		input logic signed [47:0] lo, input logic signed [47:0] hi);
		clamp = (x > hi || lo > hi) ? hi : ((x < lo) ? lo : x);
	endfunction

	// register bus: reads answer one cycle after the strobe, unmapped reads give zero
	always_comb begin
		cfg_nxt = cfg_r;
		rdata_nxt = '0;
		if (WR_I) begin
			case (ADDR_I)
				pid_pkg::REG_MAIN_SEL: cfg_nxt.main_sel = WDATA_I;
				pid_pkg::REG_REF_SEL: cfg_nxt.ref_sel = WDATA_I;
				pid_pkg::REG_FB_SEL: cfg_nxt.fb_sel = WDATA_I;
				pid_pkg::REG_CTRL: begin
					cfg_nxt.ref_inv = WDATA_I[pid_pkg::CTL_REF_INV];
					cfg_nxt.fb_inv = WDATA_I[pid_pkg::CTL_FB_INV];
					cfg_nxt.ctrl_en = WDATA_I[pid_pkg::CTL_EN];
				end
				// a zero slew time would make the ramp divider return all ones, so it is kept in range
				pid_pkg::REG_SLEW: begin
					cfg_nxt.slew = (WDATA_I < pid_pkg::SLEW_MIN) ? pid_pkg::SLEW_MIN :
						((WDATA_I > pid_pkg::SLEW_MAX) ? pid_pkg::SLEW_MAX : WDATA_I);
				end
				pid_pkg::REG_EN_SEL: cfg_nxt.en_sel = WDATA_I;
				pid_pkg::REG_KP: cfg_nxt.kp = WDATA_I;
				pid_pkg::REG_KI: cfg_nxt.ki = WDATA_I;
				pid_pkg::REG_KD: cfg_nxt.kd = WDATA_I;
				pid_pkg::REG_HI: cfg_nxt.hi = WDATA_I;
				pid_pkg::REG_LO: cfg_nxt.lo = WDATA_I;
				pid_pkg::REG_SCALE: cfg_nxt.scale = WDATA_I;
				pid_pkg::REG_DEST_SEL: cfg_nxt.dest_sel = WDATA_I;
				default: ;
			endcase
		end
		if (RD_I) begin
			case (ADDR_I)
				pid_pkg::REG_MAIN_SEL: rdata_nxt = cfg_r.main_sel;
				pid_pkg::REG_REF_SEL: rdata_nxt = cfg_r.ref_sel;
				pid_pkg::REG_FB_SEL: rdata_nxt = cfg_r.fb_sel;
				pid_pkg::REG_CTRL: rdata_nxt = {13'h0000, cfg_r.ctrl_en, cfg_r.fb_inv, cfg_r.ref_inv};
				pid_pkg::REG_SLEW: rdata_nxt = cfg_r.slew;
				pid_pkg::REG_EN_SEL: rdata_nxt = cfg_r.en_sel;
				pid_pkg::REG_KP: rdata_nxt = cfg_r.kp;
				pid_pkg::REG_KI: rdata_nxt = cfg_r.ki;
				pid_pkg::REG_KD: rdata_nxt = cfg_r.kd;
				pid_pkg::REG_HI: rdata_nxt = cfg_r.hi;
				pid_pkg::REG_LO: rdata_nxt = cfg_r.lo;
				pid_pkg::REG_SCALE: rdata_nxt = cfg_r.scale;
				pid_pkg::REG_DEST_SEL: rdata_nxt = cfg_r.dest_sel;
				pid_pkg::REG_OUT_MON: rdata_nxt = pid_r[15:0];
				pid_pkg::REG_REF_MON: rdata_nxt = 16'(ref_acc_r >>> 16);
				pid_pkg::REG_FB_MON: rdata_nxt = fb_r[15:0];
				pid_pkg::REG_ERR_MON: rdata_nxt = err_r[15:0];
				pid_pkg::REG_MAIN_MON: rdata_nxt = main_r[15:0];
				pid_pkg::REG_SCALED_MON: rdata_nxt = scaled_r[15:0];
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			cfg_r <= pid_pkg::CFG_RST;
			rdata_r <= '0;
		end else begin
			cfg_r <= cfg_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// unused or invalid enable source counts as one
	assign enabled = cfg_r.ctrl_en & ((cfg_r.en_sel == pid_pkg::UNUSED_CODE) |
		~EN_SRC_I.valid | EN_SRC_I.bit_val);

	pid_divider u_div (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.start_i(div_start),
		.dividend_i(dividend),
		.divisor_i(divisor),
		.done_o(div_done),
		.quot_o(div_quot)
	);

	// divider operands: each source is scaled as value * full scale / source maximum
	always_comb begin
		pid_pkg::src_t s;
		logic [15:0] sel;
		logic [15:0] mag;
		logic ok;
		s = '0;
		sel = pid_pkg::UNUSED_CODE;
		unique case (state_r)
			pid_pkg::ST_MAIN: begin
				s = MAIN_SRC_I;
				sel = cfg_r.main_sel;
			end
			pid_pkg::ST_REF: begin
				s = REF_SRC_I;
				sel = cfg_r.ref_sel;
			end
			pid_pkg::ST_FB: begin
				s = FB_SRC_I;
				sel = cfg_r.fb_sel;
			end
			pid_pkg::ST_IDLE, pid_pkg::ST_SLEW, pid_pkg::ST_CALC: ;
		endcase
		ok = (sel != pid_pkg::UNUSED_CODE) && s.valid && (s.max != 16'h0000);
		mag = (s.bipolar && s.value[15]) ? 16'(-s.value) : s.value;
		src_neg = ok && s.bipolar && s.value[15];
		dividend = ok ? 32'(mag) * 32'(pid_pkg::FS) : 32'h00000000;
		divisor = ok ? s.max : 16'h0001;
		if (state_r == pid_pkg::ST_SLEW) begin
			dividend = 32'(pid_pkg::SLEW_NUM);
			divisor = cfg_r.slew;
		end
	end

	assign div_start = (state_r != pid_pkg::ST_IDLE) && (state_r != pid_pkg::ST_CALC) &&
		!launched_r;
	// a source above its stated maximum is held at full scale
	assign norm = neg_r ? -clamp(48'(div_quot), 48'sh0, FS48) : clamp(48'(div_quot), 48'sh0, FS48);

	// datapath arithmetic for one sample
	always_comb begin
		tgt_fix = (cfg_r.ref_inv ? -tgt_r : tgt_r) <<< 16;
		step_fix = 48'(step_r);
		// constant rate ramp: a full-scale swing of twice the span takes twice the time
		if (ref_acc_r < tgt_fix) begin
			ref_acc_nxt = (tgt_fix - ref_acc_r > step_fix) ? ref_acc_r + step_fix : tgt_fix;
		end else begin
			ref_acc_nxt = (ref_acc_r - tgt_fix > step_fix) ? ref_acc_r - step_fix : tgt_fix;
		end
		ref_now = ref_acc_nxt >>> 16;
		err_raw = clamp(ref_now - (cfg_r.fb_inv ? -fb_r : fb_r), -FS48, FS48);
		p_term = $signed(48'(cfg_r.kp)) * err_raw / 48'(pid_pkg::GAIN_ONE);
		integ_add = $signed(48'(cfg_r.ki)) * err_raw;
		// integrator is bounded to full scale, not to the output limits, so it can wind up past them
		integ_nxt = enabled ? clamp(integ_r + integ_add, -FS48 * 48'(pid_pkg::INT_DIV),
			FS48 * 48'(pid_pkg::INT_DIV)) : 48'sh0;
		i_term = integ_nxt / 48'(pid_pkg::INT_DIV);
		d_term = $signed(48'(cfg_r.kd)) * (err_raw - err_r) * 48'(pid_pkg::D_MUL) /
			48'(pid_pkg::GAIN_ONE);
		sum = clamp(p_term + i_term + d_term, -FS48 * 48'sh4, FS48 * 48'sh4);
		hi_q = 48'($signed(cfg_r.hi)) * 48'(pid_pkg::LIM_UNIT);
		lo_q = 48'($signed(cfg_r.lo)) * 48'(pid_pkg::LIM_UNIT);
		pid_nxt = enabled ? clamp(sum, lo_q, hi_q) : 48'sh0;
		out_sum = (pid_nxt + main_r) * 48'($signed(cfg_r.scale)) / 48'(pid_pkg::GAIN_ONE);
		scaled_nxt = clamp(out_sum, -FS48, FS48);
	end

	// sequencer: main, reference, feedback, slew step, then one calculation cycle
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = (cnt_r >= 32'(SAMPLE_CYCLES - 1)) ? 32'h00000000 : cnt_r + 32'h00000001;
		launched_nxt = launched_r;
		neg_nxt = neg_r;
		main_nxt = main_r;
		tgt_nxt = tgt_r;
		fb_nxt = fb_r;
		step_nxt = step_r;
		err_nxt = err_r;
		dest_wr_nxt = 1'b0;
		dest_data_nxt = dest_data_r;
		if (div_start) begin
			launched_nxt = 1'b1;
			neg_nxt = src_neg;
		end
		if (div_done) begin
			launched_nxt = 1'b0;
		end
		unique case (state_r)
			pid_pkg::ST_IDLE: begin
				if (cnt_r == 32'h00000000) begin
					state_nxt = pid_pkg::ST_MAIN;
				end
			end
			pid_pkg::ST_MAIN: begin
				if (div_done) begin
					main_nxt = norm;
					state_nxt = pid_pkg::ST_REF;
				end
			end
			pid_pkg::ST_REF: begin
				if (div_done) begin
					tgt_nxt = norm;
					state_nxt = pid_pkg::ST_FB;
				end
			end
			pid_pkg::ST_FB: begin
				if (div_done) begin
					fb_nxt = norm;
					state_nxt = pid_pkg::ST_SLEW;
				end
			end
			pid_pkg::ST_SLEW: begin
				if (div_done) begin
					step_nxt = div_quot;
					state_nxt = pid_pkg::ST_CALC;
				end
			end
			pid_pkg::ST_CALC: begin
				err_nxt = err_raw;
				dest_wr_nxt = (cfg_r.dest_sel != pid_pkg::UNUSED_CODE) && DEST_I.valid;
				dest_data_nxt = 16'(scaled_nxt * $signed(48'(DEST_I.max)) / FS48);
				state_nxt = pid_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			state_r <= pid_pkg::ST_IDLE;
			cnt_r <= '0;
			launched_r <= 1'b0;
			neg_r <= 1'b0;
			main_r <= '0;
			tgt_r <= '0;
			fb_r <= '0;
			step_r <= '0;
			ref_acc_r <= '0;
			err_r <= '0;
			integ_r <= '0;
			pid_r <= '0;
			scaled_r <= '0;
			dest_wr_r <= 1'b0;
			dest_data_r <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			launched_r <= launched_nxt;
			neg_r <= neg_nxt;
			main_r <= main_nxt;
			tgt_r <= tgt_nxt;
			fb_r <= fb_nxt;
			step_r <= step_nxt;
			err_r <= err_nxt;
			dest_wr_r <= dest_wr_nxt;
			dest_data_r <= dest_data_nxt;
			if (state_r == pid_pkg::ST_CALC) begin
				ref_acc_r <= ref_acc_nxt;
				integ_r <= integ_nxt;
				pid_r <= pid_nxt;
				scaled_r <= scaled_nxt;
			end
		end
	end

	assign RDATA_O = rdata_r;
	assign MAIN_SEL_O = cfg_r.main_sel;
	assign REF_SEL_O = cfg_r.ref_sel;
	assign FB_SEL_O = cfg_r.fb_sel;
	assign EN_SEL_O = cfg_r.en_sel;
	assign DEST_SEL_O = cfg_r.dest_sel;
	assign DEST_WR_O = dest_wr_r;
	assign DEST_DATA_O = dest_data_r;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SRST_I);

	sequence ref_unused_s;
		state_r == pid_pkg::ST_REF && div_start && cfg_r.ref_sel == pid_pkg::UNUSED_CODE;
	endsequence
	sequence fb_reached_s;
		state_r == pid_pkg::ST_FB && tgt_r == 48'sh0;
	endsequence

	unused_ref_zero_a: assert property (ref_unused_s |-> ##[1:40] fb_reached_s)
		else $error("unused reference source did not give zero");
	disabled_out_zero_a: assert property ((state_r == pid_pkg::ST_CALC && !cfg_r.ctrl_en)
		|=> pid_r == 48'sh0)
		else $error("disabled controller output not zero");
	enable_and_a: assert property ((state_r == pid_pkg::ST_CALC && EN_SRC_I.valid &&
		cfg_r.en_sel != pid_pkg::UNUSED_CODE && !EN_SRC_I.bit_val) |=> pid_r == 48'sh0)
		else $error("enable source low did not force zero");
	unused_enable_a: assert property (cfg_r.en_sel == pid_pkg::UNUSED_CODE |->
		enabled == cfg_r.ctrl_en)
		else $error("unused enable source not treated as one");
	upper_clamp_a: assert property (state_r == pid_pkg::ST_CALC |=> pid_r <= $past(hi_q))
		else $error("output above upper limit");
	lower_clamp_a: assert property ((state_r == pid_pkg::ST_CALC && enabled && lo_q <= hi_q)
		|=> pid_r >= $past(lo_q))
		else $error("output below lower limit");
	integ_hold_a: assert property ((state_r == pid_pkg::ST_CALC && !enabled)
		|=> integ_r == 48'sh0)
		else $error("integrator not held at zero");
	ramp_step_a: assert property (state_r == pid_pkg::ST_CALC |=>
		(ref_acc_r - $past(ref_acc_r) <= $signed(48'($past(step_r)))) &&
		($past(ref_acc_r) - ref_acc_r <= $signed(48'($past(step_r)))))
		else $error("reference moved faster than the slew step");
	dest_block_a: assert property (DEST_WR_O |-> $past(cfg_r.dest_sel) != pid_pkg::UNUSED_CODE
		&& $past(DEST_I.valid))
		else $error("write to an invalid destination");
	scale_bound_a: assert property (state_r == pid_pkg::ST_CALC |=>
		scaled_r <= FS48 && scaled_r >= -FS48 && $stable(main_r))
		else $error("scaled output out of range");
endmodule

// >>> test/pid_param_bank.sv
// model of the drive parameters that feed the process controller and take its output.
// assumes the selector codes come straight from the controller; lookups answer at once.
module pid_param_bank (
	input wire logic [15:0] main_sel_i,
	input wire logic [15:0] ref_sel_i,
	input wire logic [15:0] fb_sel_i,
	input wire logic [15:0] en_sel_i,
	input wire logic [15:0] dest_sel_i,
	input wire logic [15:0] bip_val_i,
	input wire logic [15:0] uni_val_i,
	input wire logic en_bit_i,
	output pid_pkg::src_t main_src_o,
	output pid_pkg::src_t ref_src_o,
	output pid_pkg::src_t fb_src_o,
	output pid_pkg::en_src_t en_src_o,
	output pid_pkg::dest_t dest_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// codes: 0101 bipolar max 1000, 0102 unipolar max 4000, 0103 bit, 0104 destination
	function automatic pid_pkg::src_t look(input logic [15:0] sel, input logic [15:0] b,
		input logic [15:0] u);
		// unknown codes carry junk, so a design that uses the value anyway shows it
		look = '{1'b0, 1'b1, 16'h5a5a, 16'ha5a5};
		if (sel == 16'h0101) look = '{1'b1, 1'b1, b, 16'h03e8};
		if (sel == 16'h0102) look = '{1'b1, 1'b0, u, 16'h0fa0};
	endfunction
	assign main_src_o = look(main_sel_i, bip_val_i, uni_val_i);
	assign ref_src_o = look(ref_sel_i, bip_val_i, uni_val_i);
	assign fb_src_o = look(fb_sel_i, bip_val_i, uni_val_i);
	// an invalid enable source reads as zero here, the harsh case for the controller
	assign en_src_o = '{en_sel_i == 16'h0103, (en_sel_i == 16'h0103) & en_bit_i};
	assign dest_o = '{dest_sel_i == 16'h0104, 16'h05dc};
endmodule

// >>> test/tb_pid_process_controller.sv
// self-checking bench for the process controller with a parameter bank model.
// assumes a shortened sample period of 200 clocks; one sample then stands for 1 ms.
module tb_pid_process_controller;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 200;
	typedef struct packed {
		logic [15:0] fb;
		logic inv;
		logic [15:0] kp, hi, lo, sc, msel, fbm, out, dat;
	} row_t;
	row_t rows [7] = '{
		'{16'hfe0c, 1'b0, 16'h03e8, 16'h03e8, 16'hfc18, 16'h03e8, 16'h0, 16'he0c0, 16'h1f40, 16'h02ee},
		'{16'hfc18, 1'b0, 16'h03e8, 16'h03e8, 16'hfc18, 16'h03e8, 16'h0, 16'hc180, 16'h3e80, 16'h05dc},
		'{16'h00fa, 1'b1, 16'h07d0, 16'h03e8, 16'hfc18, 16'h03e8, 16'h0, 16'h0fa0, 16'h1f40, 16'h02ee},
		'{16'hfc18, 1'b0, 16'h03e8, 16'h01f4, 16'hfc18, 16'h03e8, 16'h0, 16'hc180, 16'h1f40, 16'h02ee},
		'{16'h03e8, 1'b0, 16'h03e8, 16'h03e8, 16'hff06, 16'h03e8, 16'h0, 16'h3e80, 16'hf060, 16'hfe89},
		'{16'hfe0c, 1'b0, 16'h03e8, 16'h03e8, 16'hfc18, 16'hf830, 16'h0, 16'he0c0, 16'h1f40, 16'hfa24},
		'{16'h01f4, 1'b0, 16'h03e8, 16'h03e8, 16'hfc18, 16'h03e8, 16'h0102, 16'h1f40, 16'he0c0,
			16'h02ee}};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] bip_val = 16'h0000;
	logic [15:0] uni_val = 16'h0fa0;
	logic en_bit = 1'b0;
	logic [15:0] rdata, main_sel, ref_sel, fb_sel, en_sel, dest_sel, dest_data, v, w;
	logic dest_wr;
	pid_pkg::src_t main_src, ref_src, fb_src;
	pid_pkg::en_src_t en_src;
	pid_pkg::dest_t dest;
	int num_errors = 0;
	int total_checks = 0;
	int n;

	always #2 clk = ~clk;

	pid_process_controller #(.SAMPLE_CYCLES(SC)) u_dut (.CLK_I(clk), .SRST_I(srst),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.MAIN_SEL_O(main_sel), .REF_SEL_O(ref_sel), .FB_SEL_O(fb_sel), .EN_SEL_O(en_sel),
		.DEST_SEL_O(dest_sel), .MAIN_SRC_I(main_src), .REF_SRC_I(ref_src), .FB_SRC_I(fb_src),
		.EN_SRC_I(en_src), .DEST_I(dest), .DEST_WR_O(dest_wr), .DEST_DATA_O(dest_data));

	pid_param_bank u_bank (.main_sel_i(main_sel), .ref_sel_i(ref_sel), .fb_sel_i(fb_sel),
		.en_sel_i(en_sel), .dest_sel_i(dest_sel), .bip_val_i(bip_val), .uni_val_i(uni_val),
		.en_bit_i(en_bit), .main_src_o(main_src), .ref_src_o(ref_src), .fb_src_o(fb_src),
		.en_src_o(en_src), .dest_o(dest));

	task automatic check16(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic check_flag(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		bus_rd(a, d);
		check16(d, e);
	endtask
	// returns just after a destination write, when the monitors hold still the longest
	task automatic wait_sample(input int k);
		int t;
		for (int j = 0; j < k; j++) begin
			t = 0;
			do begin
				@(posedge clk);
				#1;
				t++;
			end while (dest_wr !== 1'b1 && t < 2 * SC);
			check_flag(dest_wr, 1'b1);
		end
	endtask
	task automatic count_pulses(input int cycles, output int cnt);
		cnt = 0;
		repeat (cycles) begin
			@(posedge clk);
			#1;
			if (dest_wr !== 1'b0) cnt++;
		end
	endtask
	task automatic en_case(input logic [15:0] sel, input logic b, input logic [15:0] ctl,
		input logic [15:0] e);
		en_bit <= b;
		bus_wr(pid_pkg::REG_EN_SEL, sel);
		bus_wr(pid_pkg::REG_CTRL, ctl);
		wait_sample(2);
		rd_chk(pid_pkg::REG_OUT_MON, e);
	endtask
	task automatic ramp_to(input logic [15:0] target, output int cnt);
		logic [15:0] m;
		cnt = 0;
		do begin
			wait_sample(1);
			bus_rd(pid_pkg::REG_REF_MON, m);
			cnt++;
		end while (m !== target && cnt < 250);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd_chk(pid_pkg::REG_REF_SEL, 16'h0000);
		rd_chk(pid_pkg::REG_FB_SEL, 16'h0000);
		rd_chk(pid_pkg::REG_EN_SEL, 16'h0000);
		rd_chk(pid_pkg::REG_CTRL, 16'h0000);
		rd_chk(pid_pkg::REG_SLEW, 16'h0001);
		rd_chk(pid_pkg::REG_KP, 16'h03e8);
		rd_chk(pid_pkg::REG_KI, 16'h01f4);
		rd_chk(pid_pkg::REG_KD, 16'h0000);
		rd_chk(pid_pkg::REG_HI, 16'h03e8);
		rd_chk(pid_pkg::REG_LO, 16'hfc18);
		rd_chk(pid_pkg::REG_SCALE, 16'h03e8);
		bus_wr(8'h20, 16'hbeef);
		rd_chk(8'h20, 16'h0000);
		count_pulses(3 * SC, n);
		check16(n[15:0], 16'h0000);
		bus_wr(pid_pkg::REG_DEST_SEL, 16'h00ff);
		count_pulses(3 * SC, n);
		check16(n[15:0], 16'h0000);
		bus_wr(pid_pkg::REG_FB_SEL, 16'h0101);
		bus_wr(pid_pkg::REG_KI, 16'h0000);
		bus_wr(pid_pkg::REG_DEST_SEL, 16'h0104);
		for (int i = 0; i < 7; i++) begin
			bip_val <= rows[i].fb;
			bus_wr(pid_pkg::REG_CTRL, {13'h0000, 1'b1, rows[i].inv, 1'b0});
			bus_wr(pid_pkg::REG_KP, rows[i].kp);
			bus_wr(pid_pkg::REG_HI, rows[i].hi);
			bus_wr(pid_pkg::REG_LO, rows[i].lo);
			bus_wr(pid_pkg::REG_SCALE, rows[i].sc);
			bus_wr(pid_pkg::REG_MAIN_SEL, rows[i].msel);
			wait_sample(2);
			rd_chk(pid_pkg::REG_OUT_MON, rows[i].out);
			rd_chk(pid_pkg::REG_FB_MON, rows[i].fbm);
			rd_chk(pid_pkg::REG_MAIN_MON, (rows[i].msel == 16'h0) ? 16'h0 : 16'h3e80);
			check16(dest_data, rows[i].dat);
		end
		bus_wr(pid_pkg::REG_FB_SEL, 16'h00ff);
		wait_sample(2);
		rd_chk(pid_pkg::REG_FB_MON, 16'h0000);
		bus_wr(pid_pkg::REG_FB_SEL, 16'h0101);
		bip_val <= 16'hfe0c;
		bus_wr(pid_pkg::REG_MAIN_SEL, 16'h0000);
		bus_wr(pid_pkg::REG_KP, 16'h03e8);
		bus_wr(pid_pkg::REG_SCALE, 16'h03e8);
		en_case(16'h0103, 1'b1, 16'h0004, 16'h1f40);
		en_case(16'h0103, 1'b0, 16'h0004, 16'h0000);
		en_case(16'h00ff, 1'b0, 16'h0004, 16'h1f40);
		en_case(16'h0000, 1'b0, 16'h0004, 16'h1f40);
		en_case(16'h0000, 1'b1, 16'h0000, 16'h0000);
		bip_val <= 16'hfc18;
		bus_wr(pid_pkg::REG_KP, 16'h0000);
		bus_wr(pid_pkg::REG_KI, 16'h03e8);
		bus_wr(pid_pkg::REG_CTRL, 16'h0004);
		wait_sample(1);
		bus_rd(pid_pkg::REG_OUT_MON, v);
		wait_sample(1);
		bus_rd(pid_pkg::REG_OUT_MON, w);
		check16(w - v, 16'h0010);
		bus_wr(pid_pkg::REG_KI, 16'h01f4);
		wait_sample(1);
		bus_rd(pid_pkg::REG_OUT_MON, v);
		wait_sample(1);
		bus_rd(pid_pkg::REG_OUT_MON, w);
		check16(w - v, 16'h0008);
		bus_wr(pid_pkg::REG_CTRL, 16'h0000);
		wait_sample(1);
		rd_chk(pid_pkg::REG_OUT_MON, 16'h0000);
		bus_wr(pid_pkg::REG_CTRL, 16'h0004);
		wait_sample(1);
		bus_rd(pid_pkg::REG_OUT_MON, w);
		check_flag(w <= 16'h0008, 1'b1);
		bus_wr(pid_pkg::REG_KI, 16'h0000);
		bus_wr(pid_pkg::REG_CTRL, 16'h0000);
		wait_sample(1);
		bus_wr(pid_pkg::REG_CTRL, 16'h0004);
		bus_wr(pid_pkg::REG_KD, 16'h01f4);
		wait_sample(2);
		rd_chk(pid_pkg::REG_OUT_MON, 16'h0000);
		bip_val <= 16'hfc19;
		wait_sample(1);
		rd_chk(pid_pkg::REG_OUT_MON, 16'he0c0);
		wait_sample(1);
		rd_chk(pid_pkg::REG_OUT_MON, 16'h0000);
		bus_wr(pid_pkg::REG_KD, 16'h0000);
		bus_wr(pid_pkg::REG_FB_SEL, 16'h0000);
		bus_wr(pid_pkg::REG_REF_SEL, 16'h0102);
		ramp_to(16'h3e80, n);
		check_flag(n >= 99 && n <= 102, 1'b1);
		bus_wr(pid_pkg::REG_CTRL, 16'h0005);
		ramp_to(16'h0000, n);
		check_flag(n >= 99 && n <= 102, 1'b1);
		wait_sample(1);
		rd_chk(pid_pkg::REG_REF_MON, 16'hff60);
		tally_and_finish();
	end
endmodule
